/* File: core/tx_dma_pkg.sv */
package tx_dma_pkg;

  // ==========================================================
  // Register byte offsets
  // ==========================================================
  localparam logic [7:0] OFF_CUR_BUF   = 8'h00;
  localparam logic [7:0] OFF_BUF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_PKT_LEN   = 8'h08;
  localparam logic [7:0] OFF_COMPL     = 8'h0c;
  localparam logic [7:0] OFF_DMA_STATE = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h18;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int TAG_HI    = 31;
  localparam int TAG_LO    = 24;
  localparam int LAST_BIT  = 17;
  localparam int FIRST_BIT = 16;
  localparam int LEN_HI    = 15;
  localparam int LEN_LO    = 0;
  localparam int REM_HI    = 31;
  localparam int REM_LO    = 16;
  localparam int DADDR_HI  = 31;
  localparam int DADDR_LO  = 2;
  localparam int MODE_BIT  = 0;
  localparam int INPKT_BIT = 0;

  // Interrupt status bits
  localparam int IRQ_W     = 2;
  localparam int ST_QUEUE  = 0;
  localparam int ST_TRUNC  = 1;

  // ==========================================================
  // Constants
  // ==========================================================
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONE16  = 16'h0001;
  localparam logic [31:0] ONE32  = 32'h0000_0001;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

endpackage

/* File: core/tx_dma_channel.sv */
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Keeps the 32-bit byte address being fetched in the active buffer.
// - Holds the first descriptor's tag byte and offers it to receive.
// - Flags when the active buffer is the packet's last buffer.
// - Flags when the active buffer is the packet's first buffer.
// - Counts the valid bytes still left in the active buffer.
// - Counts bytes allowed before truncation and truncates at zero.
// - Loads packet length from the first descriptor's length word.
// - Presents the stored packet length for the AAL5 trailer.
// - Records the word address of the descriptor active at the last packet end or truncation.
// - Compare-mode write clears the queue interrupt only on a match.
// - Writeback-mode write stores the address and raises the interrupt.
// - The completion write mode bit always reads as zero.
// - All state fields except cur_desc_q are readable by software, writable except the W1C status bits, and all reset to zero.
// - Keeps an in-packet flag while partway through a packet.

module tx_dma_channel
  import tx_dma_pkg::*;
(
  input  wire logic        clock,         // 100 MHz clock
  input  wire logic        sys_rst,       // Sync reset, high
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Byte address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write when high
  input  wire logic [2:0]  hsize,         // Word only
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready
  output logic             hreadyout,     // Low in reset, then ready
  output logic [31:0]      hrdata,        // Read data
  output logic             hresp,         // Always OKAY
  input  wire logic        desc_load,     // New buffer descriptor
  input  wire logic [29:0] last_done_descriptor_address,     // Its word address
  input  wire logic [31:0] desc_buf_addr, // Buffer start byte
  input  wire logic [15:0] desc_buf_len,  // Buffer byte count
  input  wire logic        desc_first,    // Start of packet
  input  wire logic        desc_last,     // End of packet
  input  wire logic [7:0]  desc_tag,      // Tag byte (first only)
  input  wire logic [15:0] desc_pkt_len,  // Packet length (first)
  input  wire logic        byte_fetch,    // One byte fetched
  output logic [31:0]      fetch_addr,    // Next byte address
  output logic [7:0]       packet_tag,    // Tag to receive side
  output logic [15:0]      trailer_len,   // AAL5 trailer length
  output logic             truncate,      // Truncation pulse
  output logic             packet_done,   // Packet end pulse
  output logic             irq            // Level interrupt
);

  // ==========================================================
  // State
  // ==========================================================
  // Register map, one aligned word per register:
  //   0x00 active buffer byte address
  //   0x04 tag [31:24], last [17], first [16], bytes left [15:0]
  //   0x08 bytes before truncation [31:16], packet length [15:0]
  //   0x0c completion address [31:2], write mode bit 0 (reads 0)
  //   0x10 in-packet flag, bit 0
  //   0x14 status: bit 0 queue done, bit 1 truncation (W1C)
  //   0x18 interrupt mask, same layout as status

  // Channel state, software-visible except cur_desc_q
  logic [31:0]      buf_addr_q;
  logic [7:0]       tag_q;
  logic             last_q;
  logic             first_q;
  logic [15:0]      buf_len_q;
  logic [15:0]      pkt_len_q;
  logic [15:0]      rem_q;
  logic [29:0]      done_addr_q;
  logic [29:0]      cur_desc_q;
  logic             in_pkt_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] mask_q;

  // Bus write capture and read path
  logic             wr_q;
  logic [7:0]       wr_off_q;
  logic [31:0]      rd_mux;

  // Fetch events and one-hot write strobes
  logic             fetch_ok;
  logic             buf_final;
  logic             pkt_end;
  logic             trunc_ev;
  logic             wr_cur;
  logic             wr_flags;
  logic             wr_len;
  logic             wr_compl;
  logic             wr_state;
  logic             wr_stat;
  logic             wr_mask;
  logic             wb_write;
  logic             cmp_match;

  // ==========================================================
  // AHB-Lite slave
  // ==========================================================
  wire addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);

  // Zero wait states: after reset the slave never stalls the master
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hreadyout <= 1'b0;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  // Capture the write address phase; data lands next cycle
  // Limitation: a read right after a write sees the old value, as
  // the write only lands at the end of its data phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_q     <= 1'b0;
      wr_off_q <= 8'h00;
    end else begin
      wr_q     <= addr_ok && hwrite;
      wr_off_q <= haddr[7:0];
    end
  end

  // Write strobes, valid during the data phase
  assign wr_cur   = wr_q && (wr_off_q == OFF_CUR_BUF);
  assign wr_flags = wr_q && (wr_off_q == OFF_BUF_FLAGS);
  assign wr_len   = wr_q && (wr_off_q == OFF_PKT_LEN);
  assign wr_compl = wr_q && (wr_off_q == OFF_COMPL);
  assign wr_state = wr_q && (wr_off_q == OFF_DMA_STATE);
  assign wr_stat  = wr_q && (wr_off_q == OFF_IRQ_STAT);
  assign wr_mask  = wr_q && (wr_off_q == OFF_IRQ_MASK);

  // Read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    rd_mux = ZERO32;
    case (haddr[7:0])
      OFF_CUR_BUF: rd_mux = buf_addr_q;
      OFF_BUF_FLAGS: begin
        rd_mux[TAG_HI:TAG_LO] = tag_q;
        rd_mux[LAST_BIT]      = last_q;
        rd_mux[FIRST_BIT]     = first_q;
        rd_mux[LEN_HI:LEN_LO] = buf_len_q;
      end
      OFF_PKT_LEN: begin
        rd_mux[REM_HI:REM_LO] = rem_q;
        rd_mux[LEN_HI:LEN_LO] = pkt_len_q;
      end
      OFF_COMPL: begin
        // Mode bit is write-only and reads as zero
        rd_mux[DADDR_HI:DADDR_LO] = done_addr_q;
      end
      OFF_DMA_STATE: rd_mux[INPKT_BIT] = in_pkt_q;
      OFF_IRQ_STAT:  rd_mux[IRQ_W-1:0] = stat_q;
      OFF_IRQ_MASK:  rd_mux[IRQ_W-1:0] = mask_q;
      default:       rd_mux = ZERO32;
    endcase
  end

  // Read data is registered at the address phase edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hrdata <= ZERO32;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // ==========================================================
  // Fetch-side events
  // ==========================================================
  // Bytes past the truncation point or past the buffer end are
  // dropped, so a runaway fetcher cannot wrap the counters
  // A fetch in the reload cycle is ignored, so the counters and the
  // packet end never act on a half-loaded descriptor
  assign fetch_ok  = byte_fetch && !desc_load
                     && (rem_q != ZERO16)
                     && (buf_len_q != ZERO16);
  assign buf_final = (buf_len_q == ONE16) && last_q;
  // Packet ends on the last byte of the last buffer, or when
  // the truncation budget runs out
  assign pkt_end   = fetch_ok && (buf_final || rem_q == ONE16);
  assign trunc_ev  = fetch_ok && (rem_q == ONE16) && !buf_final;

  // ==========================================================
  // Buffer address and flags
  // ==========================================================
  // Software write wins over hardware stepping in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      buf_addr_q <= ZERO32;
    end else if (wr_cur) begin
      buf_addr_q <= hwdata;
    end else if (desc_load) begin
      buf_addr_q <= desc_buf_addr;
    end else if (fetch_ok) begin
      buf_addr_q <= buf_addr_q + ONE32;
    end
  end

  // First/last flags follow the buffer now being sent
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      first_q <= 1'b0;
      last_q  <= 1'b0;
    end else if (wr_flags) begin
      first_q <= hwdata[FIRST_BIT];
      last_q  <= hwdata[LAST_BIT];
    end else if (desc_load) begin
      first_q <= desc_first;
      last_q  <= desc_last;
    end
  end

  // Bytes left in the active buffer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      buf_len_q <= ZERO16;
    end else if (wr_flags) begin
      buf_len_q <= hwdata[LEN_HI:LEN_LO];
    end else if (desc_load) begin
      buf_len_q <= desc_buf_len;
    end else if (fetch_ok) begin
      buf_len_q <= buf_len_q - ONE16;
    end
  end

  // Tag comes only from the first descriptor of a packet
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tag_q <= 8'h00;
    end else if (wr_flags) begin
      tag_q <= hwdata[TAG_HI:TAG_LO];
    end else if (desc_load && desc_first) begin
      tag_q <= desc_tag;
    end
  end

  // ==========================================================
  // Packet length and truncation budget
  // ==========================================================
  // Budget starts at the packet length; software may preset both
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pkt_len_q <= ZERO16;
      rem_q     <= ZERO16;
    end else if (wr_len) begin
      pkt_len_q <= hwdata[LEN_HI:LEN_LO];
      rem_q     <= hwdata[REM_HI:REM_LO];
    end else if (desc_load && desc_first) begin
      pkt_len_q <= desc_pkt_len;
      rem_q     <= desc_pkt_len;
    end else if (fetch_ok) begin
      rem_q     <= rem_q - ONE16;
    end
  end

  // In-packet flag: up at the first buffer, down at packet end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      in_pkt_q <= 1'b0;
    end else if (wr_state) begin
      in_pkt_q <= hwdata[INPKT_BIT];
    end else if (desc_load && desc_first) begin
      in_pkt_q <= 1'b1;
    end else if (pkt_end) begin
      in_pkt_q <= 1'b0;
    end
  end

  // ==========================================================
  // Completion pointer
  // ==========================================================
  // Mode bit 1 writes the address back; mode bit 0 only compares,
  // so software can acknowledge without losing a newer completion
  assign wb_write  = wr_compl && hwdata[MODE_BIT];
  assign cmp_match = wr_compl && !hwdata[MODE_BIT]
                     && (hwdata[DADDR_HI:DADDR_LO] == done_addr_q);

  // Descriptor of the buffer now being sent
  // Held until the next reload, for the completion address
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur_desc_q <= 30'h0000_0000;
    end else if (desc_load) begin
      cur_desc_q <= last_done_descriptor_address;
    end
  end

  // Compare-mode writes never change the stored address
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done_addr_q <= 30'h0000_0000;
    end else if (wb_write) begin
      done_addr_q <= hwdata[DADDR_HI:DADDR_LO];
    end else if (pkt_end) begin
      done_addr_q <= cur_desc_q;
    end
  end

  // ==========================================================
  // Interrupts
  // ==========================================================
  // Queue bit: raised by completion or writeback, dropped by a
  // matching compare or a write-one-to-clear. Setting wins, so
  // a packet ending during the acknowledge is never lost
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stat_q[ST_QUEUE] <= 1'b0;
    end else if (pkt_end || wb_write) begin
      stat_q[ST_QUEUE] <= 1'b1;
    end else if (cmp_match) begin
      stat_q[ST_QUEUE] <= 1'b0;
    end else if (wr_stat && hwdata[ST_QUEUE]) begin
      stat_q[ST_QUEUE] <= 1'b0;
    end
  end

  // Truncation bit is sticky until written with a one
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stat_q[ST_TRUNC] <= 1'b0;
    end else if (trunc_ev) begin
      stat_q[ST_TRUNC] <= 1'b1;
    end else if (wr_stat && hwdata[ST_TRUNC]) begin
      stat_q[ST_TRUNC] <= 1'b0;
    end
  end

  // Mask gates status onto the interrupt line only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= hwdata[IRQ_W-1:0];
    end
  end

  // Registered output adds one cycle of latency after a status change
  // so irq trails the status bit by one clock
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  // ==========================================================
  // Fetch-side outputs
  // ==========================================================
  // One-cycle pulses, registered so that they are glitch free
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      truncate    <= 1'b0;
      packet_done <= 1'b0;
    end else begin
      truncate    <= trunc_ev;
      packet_done <= pkt_end;
    end
  end

  // Copies of state; one cycle behind the internal registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fetch_addr  <= ZERO32;
      packet_tag  <= 8'h00;
      trailer_len <= ZERO16;
    end else begin
      fetch_addr  <= buf_addr_q;
      packet_tag  <= tag_q;
      trailer_len <= pkt_len_q;
    end
  end

endmodule

/* File: tb/tx_dma_checker_assertions.sv */
`timescale 1ns/1ps
// ==========================================
// Bus and fetch checker
module tx_dma_checker (
  input wire logic        clock,         // Clock
  input wire logic        sys_rst,       // Sync reset
  input wire logic        hsel,          // Select
  input wire logic [31:0] haddr,         // Address
  input wire logic [1:0]  htrans,        // Transfer
  input wire logic        hwrite,        // Write
  input wire logic        hready,        // Ready in
  input wire logic [31:0] hrdata,        // Read data
  input wire logic        desc_load,     // Reload
  input wire logic [31:0] desc_buf_addr, // Start
  input wire logic        desc_first,    // First
  input wire logic [7:0]  desc_tag,      // Tag
  input wire logic [15:0] desc_pkt_len,  // Length
  input wire logic        byte_fetch,    // Fetch
  input wire logic [31:0] fetch_addr,    // Address copy
  input wire logic [7:0]  packet_tag,    // Tag copy
  input wire logic [15:0] trailer_len,   // Length copy
  input wire logic        truncate,      // Trunc pulse
  input wire logic        packet_done,   // Done pulse
  input wire logic        irq            // Interrupt
);
  import tx_dma_pkg::*;
  logic req;
  logic wr;
  // Accepted address phases
  assign req = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign wr = req & hwrite;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_addr;
    desc_load |-> ##2 fetch_addr == $past(desc_buf_addr, 2);
  endproperty
  a_addr: assert property (p_addr) else $error("reload address");
  property p_tag;
    desc_load && desc_first |-> ##2 packet_tag == $past(desc_tag, 2);
  endproperty
  a_tag: assert property (p_tag) else $error("tag copy");
  property p_len;
    desc_load && desc_first |-> ##2 trailer_len == $past(desc_pkt_len, 2);
  endproperty
  a_len: assert property (p_len) else $error("length copy");
  property p_tpulse;
    truncate |=> !truncate;
  endproperty
  a_tpulse: assert property (p_tpulse) else $error("trunc width");
  property p_tend;
    truncate |-> packet_done;
  endproperty
  a_tend: assert property (p_tend) else $error("trunc no end");
  property p_done;
    packet_done |-> $past(byte_fetch);
  endproperty
  a_done: assert property (p_done) else $error("done cause");
  property p_rise;
    $rose(irq) |-> $past(packet_done) || $past(wr, 3);
  endproperty
  a_rise: assert property (p_rise) else $error("irq rise");
  property p_fall;
    $fell(irq) |-> $past(wr, 3);
  endproperty
  a_fall: assert property (p_fall) else $error("irq fall");
  property p_mode;
    req && !hwrite && haddr[7:0] == OFF_COMPL |=> hrdata[MODE_BIT] == 1'b0;
  endproperty
  a_mode: assert property (p_mode) else $error("mode bit read");
  property p_rsvd;
    req && !hwrite && haddr[7:0] == OFF_BUF_FLAGS |=> hrdata[23:18] == 6'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");
  c_trunc: cover property (truncate);
  c_done: cover property (packet_done);
  c_fall: cover property ($fell(irq));
endmodule

bind tx_dma_channel tx_dma_checker chk (.*);

/* File: tb/buf_mem_model.sv */
`timescale 1ns/1ps
// ==========================================
// Descriptor and buffer memory
module buf_mem_model (
  input  wire logic  clock,         // Clock
  output logic       desc_load,     // Reload
  output logic [29:0] last_done_descriptor_address,    // Descriptor word
  output logic [31:0] desc_buf_addr, // Start
  output logic [15:0] desc_buf_len, // Bytes
  output logic       desc_first,    // First
  output logic       desc_last,     // Last
  output logic [7:0] desc_tag,      // Tag
  output logic [15:0] desc_pkt_len, // Length
  output logic       byte_fetch     // Fetch
);
  // Fields are inverted when not loading, like a released bus
  task automatic send_buf(input logic [29:0] da, input logic [31:0] ba,
    input logic [15:0] bl, input logic [1:0] fl, input logic [7:0] tg,
    input logic [15:0] pl, input int n, input int gap);
    desc_load <= 1'b1;
    {last_done_descriptor_address, desc_buf_addr, desc_buf_len} <= {da, ba, bl};
    {desc_last, desc_first, desc_tag, desc_pkt_len} <= {fl, tg, pl};
    @(posedge clock);
    desc_load <= 1'b0;
    {last_done_descriptor_address, desc_buf_addr, desc_buf_len} <= ~{da, ba, bl};
    {desc_last, desc_first, desc_tag, desc_pkt_len} <= ~{fl, tg, pl};
    // A gap models a slow memory
    for (int i = 0; i < n; i++) begin
      if (gap > 0) begin
        byte_fetch <= 1'b0;
        repeat (gap) @(posedge clock);
      end
      byte_fetch <= 1'b1;
      @(posedge clock);
    end
    byte_fetch <= 1'b0;
  endtask
  initial begin
    {desc_load, byte_fetch, desc_first, desc_last} = 4'h0;
    {last_done_descriptor_address, desc_buf_addr, desc_buf_len} = '0;
    {desc_tag, desc_pkt_len} = '0;
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import tx_dma_pkg::*;
  logic clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr, hwdata, hrdata, desc_buf_addr, fetch_addr, rd;
  logic desc_load, desc_first, desc_last, byte_fetch;
  logic truncate, packet_done, irq;
  logic [29:0] last_done_descriptor_address;
  logic [15:0] desc_buf_len, desc_pkt_len, trailer_len;
  logic [7:0] desc_tag, packet_tag;
  int n_fail, tests_run, n_trunc, n_done;
  assign hready = hreadyout;
  tx_dma_channel DUT (.*);
  buf_mem_model MEM (.*);
  always #5 clock = ~clock;
  // Count output pulses
  always @(posedge clock) begin
    if (truncate === 1'b1) n_trunc++;
    if (packet_done === 1'b1) n_done++;
  end
  // ==========================================
  // Tasks
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait for ready at a rising edge
  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      n_fail++;
      print_verdict;
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, HTRANS_NONSEQ, 24'h0, a};
    wait_ready;
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    wait_ready;
    rd = hrdata;
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, ZERO32);
    check(rd, e);
  endtask
  task automatic irq_check(input logic e);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, {31'h0, e});
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {clock, sys_rst, hsel, hwrite, htrans, haddr, hwdata} = '0;
    sys_rst = 1'b1;
    {n_fail, tests_run, n_trunc, n_done} = '0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    // Reset values, last one unmapped
    for (int i = 0; i < 8; i++) rd_check(8'(i * 4), ZERO32);
    check({31'h0, hresp}, ZERO32);
    bus(OFF_CUR_BUF, 1'b1, 32'hdeadbeef);
    rd_check(OFF_CUR_BUF, 32'hdeadbeef);
    bus(OFF_BUF_FLAGS, 1'b1, '1);
    rd_check(OFF_BUF_FLAGS, 32'hff03ffff);
    bus(OFF_PKT_LEN, 1'b1, 32'h1234abcd);
    rd_check(OFF_PKT_LEN, 32'h1234abcd);
    check({16'h0, trailer_len}, 32'habcd);
    bus(OFF_DMA_STATE, 1'b1, '1);
    rd_check(OFF_DMA_STATE, ONE32);
    bus(OFF_DMA_STATE, 1'b1, ZERO32);
    // Completion pointer: writeback, masked, mismatch, match
    bus(OFF_COMPL, 1'b1, 32'h00001235);
    rd_check(OFF_COMPL, 32'h00001234);
    irq_check(1'b0);
    bus(OFF_IRQ_MASK, 1'b1, 32'h3);
    irq_check(1'b1);
    bus(OFF_COMPL, 1'b1, 32'h00001238);
    rd_check(OFF_IRQ_STAT, ONE32);
    bus(OFF_COMPL, 1'b1, 32'h00001234);
    rd_check(OFF_IRQ_STAT, ZERO32);
    irq_check(1'b0);
    // Two-buffer packet, second buffer from a slow memory
    MEM.send_buf(30'h40, 32'h1000, 16'h2, 2'b01, 8'ha5, 16'h3, 2, 0);
    rd_check(OFF_DMA_STATE, ONE32);
    rd_check(OFF_BUF_FLAGS, 32'ha5010000);
    MEM.send_buf(30'h41, 32'h2000, 16'h1, 2'b10, 8'h00, 16'h0, 1, 3);
    repeat (3) @(posedge clock);
    rd_check(OFF_CUR_BUF, 32'h00002001);
    rd_check(OFF_BUF_FLAGS, 32'ha5020000);
    rd_check(OFF_PKT_LEN, 32'h00000003);
    rd_check(OFF_COMPL, 32'h00000104);
    rd_check(OFF_DMA_STATE, ZERO32);
    check({24'h0, packet_tag}, 32'ha5);
    check({16'h0, trailer_len}, 32'h3);
    check({31'h0, irq}, ONE32);
    bus(OFF_COMPL, 1'b1, 32'h00000104);
    // Truncation mid-buffer; the extra fetch is refused
    MEM.send_buf(30'h50, 32'h3000, 16'h4, 2'b01, 8'h3c, 16'h2, 3, 0);
    repeat (3) @(posedge clock);
    check(32'(n_trunc), ONE32);
    check(32'(n_done), 32'h2);
    rd_check(OFF_CUR_BUF, 32'h00003002);
    check(fetch_addr, 32'h00003002);
    rd_check(OFF_BUF_FLAGS, 32'h3c010002);
    rd_check(OFF_IRQ_STAT, 32'h3);
    bus(OFF_IRQ_STAT, 1'b1, 32'h3);
    rd_check(OFF_IRQ_STAT, ZERO32);
    irq_check(1'b0);
    print_verdict;
  end
endmodule
